// ==== adl_bridge.v ====
`timescale 1ns/1ps
`include "adl_map.vh"

// Functional notes
// - 16-bit writable absent-device log at offset CCh, resets to zero.
// - log bit n stands for device number n plus 16 on bus 0.
// - log bit set means device unpopulated; clear means device present.
// - access to a logged-absent device is claimed and forwarded to PCI.
// - with log bit clear, absent-device accesses end by watchdog timer.
// - writing 1 to decode mode bit 3 enables aliased mode.
// - with error command bit 1 set, address parity error raises bus error.
module adl_bridge #(
  parameter WDOG_CYCLES = `ADL_WDOG_CYCLES,
  parameter WDOG_W      = 16
) (
  input  wire        clk,
  input  wire        rstn,
  // configuration register port
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  output reg         cfg_rvalid,
  // host bus configuration request
  input  wire        req_valid,
  input  wire [7:0]  req_bus,
  input  wire [4:0]  req_dev,
  input  wire        req_taken,
  output reg         req_busy,
  output reg         pci_fwd,
  output reg         wdog_claim,
  // error signalling and mode
  input  wire        address_parity_error_n,
  output reg         host_bus_error_n,
  output reg         aliased_mode
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;
  // last count before the watchdog claims; worked out wide, cut on purpose
  localparam integer      WDOG_LAST_I = WDOG_CYCLES - 1;
  localparam [WDOG_W-1:0] WDOG_LAST   = WDOG_LAST_I[WDOG_W-1:0];

  reg              rst_s1_r;
  reg              rst_s2_r;
  wire             rst_n_i;
  // configuration registers
  reg  [7:0]       decode_mode_r;
  reg  [31:0]      err_cmd_r;
  reg  [15:0]      absent_log_r;
  // request path
  reg              state_r;
  reg  [WDOG_W-1:0] wdog_cnt_r;
  reg  [31:0]      rdata_nxt;
  wire             in_window;
  wire [3:0]       log_idx;
  wire             logged_absent;
  // write selects
  wire             wr_mode;
  wire             wr_err;
  wire             wr_log;

  // reset released through two flops so no flop sees a raw release edge
  // assertion still acts at once; only the release waits two edges
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n_i = rst_s2_r;

  // write selects, one per mapped register; other offsets are ignored
  assign wr_mode = cfg_wr && (cfg_addr == `ADL_OFF_DECODE_MODE);
  assign wr_err  = cfg_wr && (cfg_addr == `ADL_OFF_ERR_CMD);
  assign wr_log  = cfg_wr && (cfg_addr == `ADL_OFF_ABSENT_LOG);

  // decode mode: a plain byte, of which only bit 3 matters here
  always @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      decode_mode_r <= `ADL_RST_DECODE_MODE;
    end else if (wr_mode && cfg_be[0]) begin
      decode_mode_r <= cfg_wdata[7:0];
    end
  end

  // error command: all four lanes writable, disabled lanes kept
  always @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_cmd_r <= `ADL_RST_ERR_CMD;
    end else if (wr_err) begin
      if (cfg_be[0])
        err_cmd_r[7:0] <= cfg_wdata[7:0];
      if (cfg_be[1])
        err_cmd_r[15:8] <= cfg_wdata[15:8];
      if (cfg_be[2])
        err_cmd_r[23:16] <= cfg_wdata[23:16];
      if (cfg_be[3])
        err_cmd_r[31:24] <= cfg_wdata[31:24];
    end
  end

  // absent-device log: 16 bits wide, so lanes 2 and 3 fall away
  always @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      absent_log_r <= `ADL_RST_ABSENT_LOG;
    end else if (wr_log) begin
      if (cfg_be[0])
        absent_log_r[7:0] <= cfg_wdata[7:0];
      if (cfg_be[1])
        absent_log_r[15:8] <= cfg_wdata[15:8];
    end
  end

  // read mux; unmapped offsets read as zero
  // a read and a write in one cycle return the old value
  always @* begin
    rdata_nxt = 32'h00000000;
    case (cfg_addr)
      `ADL_OFF_DECODE_MODE: rdata_nxt = {24'h000000, decode_mode_r};
      `ADL_OFF_ERR_CMD:     rdata_nxt = err_cmd_r;
      `ADL_OFF_ABSENT_LOG:  rdata_nxt = {16'h0000, absent_log_r};
      default:              rdata_nxt = 32'h00000000;
    endcase
  end

  // read data registered, one cycle after the strobe
  always @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= rdata_nxt;
    end
  end

  // device numbers 16..31 on bus 0 index the log by their low four bits
  assign in_window = (req_bus == `ADL_HOST_BUS) &&
                     (req_dev >= `ADL_DEV_BASE);
  // bit n covers device n + 16; the window test keeps low numbers out
  assign log_idx = req_dev[3:0];
  // a set bit marks the slot empty
  assign logged_absent = in_window && absent_log_r[log_idx];

  // request handling: positive decode for logged slots, else watchdog
  always @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= ST_IDLE;
      wdog_cnt_r <= {WDOG_W{1'b0}};
      req_busy   <= 1'b0;
      pci_fwd    <= 1'b0;
      wdog_claim <= 1'b0;
    end else begin
      pci_fwd    <= 1'b0;
      wdog_claim <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (req_valid) begin
            if (logged_absent) begin
              // master abort on PCI is far quicker than the watchdog
              pci_fwd <= 1'b1;
            end else if (!req_taken) begin
              // nobody took it at once, so start timing
              state_r    <= ST_WAIT;
              wdog_cnt_r <= {WDOG_W{1'b0}};
              req_busy   <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          // a new request here is dropped, not queued
          if (req_taken) begin
            state_r  <= ST_IDLE;
            req_busy <= 1'b0;
          end else if (wdog_cnt_r == WDOG_LAST) begin
            // nobody answered: the watchdog claims and ends the cycle
            wdog_claim <= 1'b1;
            state_r    <= ST_IDLE;
            req_busy   <= 1'b0;
          end else begin
            wdog_cnt_r <= wdog_cnt_r + {{(WDOG_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_r  <= ST_IDLE;
          req_busy <= 1'b0;
        end
      endcase
    end
  end

  // parity error converted to bus error only when enabled; a level that
  // follows the input one clock late, not a stretched pulse
  always @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_bus_error_n <= 1'b1;
    end else begin
      host_bus_error_n <= ~(err_cmd_r[`ADL_BIT_APE_TO_HBE] &
                            ~address_parity_error_n);
    end
  end

  // aliased mode flag; the host must not lock write-protected shadowed
  // firmware while it is set, nothing here can stop such a lock
  always @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aliased_mode <= 1'b0;
    end else begin
      aliased_mode <= decode_mode_r[`ADL_BIT_ALIASED];
    end
  end

endmodule // adl_bridge

// ==== adl_map.vh ====
`ifndef ADL_MAP_VH
`define ADL_MAP_VH

// configuration space byte offsets (dword aligned)
`define ADL_OFF_DECODE_MODE   8'h48
`define ADL_OFF_ERR_CMD       8'hC0
`define ADL_OFF_ABSENT_LOG    8'hCC

// reset values
`define ADL_RST_DECODE_MODE   8'h06
`define ADL_RST_ERR_CMD       32'h00000010
`define ADL_RST_ABSENT_LOG    16'h0000

// field positions
`define ADL_BIT_ALIASED       3
`define ADL_BIT_APE_TO_HBE    1

// device number window covered by the absent-device log
`define ADL_DEV_BASE          5'h10
`define ADL_HOST_BUS          8'h00

// default watchdog interval in clock cycles
`define ADL_WDOG_CYCLES       256

`endif

// ==== adl_chk_checker.sv ====
`timescale 1ns/1ps
module adl_chk #(parameter int WDOG_CYCLES = 8) (
  input wire logic clk, rstn, cfg_wr, cfg_rd, cfg_rvalid, req_valid,
  input wire logic req_taken, req_busy, pci_fwd, wdog_claim, aliased_mode,
  input wire logic address_parity_error_n, host_bus_error_n,
  input wire logic [7:0] cfg_addr, req_bus,
  input wire logic [4:0] req_dev,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata, cfg_rdata);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // every read gets exactly one ack, never a stray one
  rd_ack_a: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read not acknowledged");
  rd_stray_a: assert property (!cfg_rd |=> !cfg_rvalid)
    else $error("stray read ack");
  fwd_src_a: assert property (pci_fwd |-> $past(req_valid) &&
    $past(req_dev[4]) && $past(req_bus) == 8'h00)
    else $error("forward without bus 0 upper device request");
  fwd_solo_a: assert property (pci_fwd |-> !req_busy && !wdog_claim)
    else $error("forwarded request also timed");
  wd_len_a: assert property (
    $rose(req_busy) |-> ##WDOG_CYCLES wdog_claim)
    else $error("watchdog interval wrong");
  wd_end_a: assert property (
    wdog_claim |-> !req_busy && $past(req_busy))
    else $error("watchdog claim outside a timed request");
  host_bus_error_src_a: assert property (!host_bus_error_n |->
    !$past(address_parity_error_n)) else $error("bus error without cause");
  alias_wr_a: assert property (
    cfg_wr && cfg_addr == 8'h48 && cfg_be[0] |=> ##1
    aliased_mode == $past(cfg_wdata[3], 2)) else $error("aliased mode stale");
  cover property (pci_fwd);
  cover property (wdog_claim);
  cover property (!host_bus_error_n);
  cover property ($rose(aliased_mode));
endmodule // adl_chk
bind adl_bridge adl_chk #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (.*);

// ==== adl_agent.sv ====
`timescale 1ns/1ps
// far side: populated devices claim at once, absent ones stay silent
module adl_agent (
  input wire logic [15:0] pop,
  input wire logic        req_valid,
  input wire logic [7:0]  req_bus,
  input wire logic [4:0]  req_dev,
  output logic            req_taken);
  assign req_taken = req_valid && req_bus == 8'h00 && req_dev[4] &&
                     pop[req_dev[3:0]];
endmodule // adl_agent

// ==== adl_bridge_tb.sv ====
`timescale 1ns/1ps
`include "adl_map.vh"
module adl_bridge_tb;
  logic clk = 0, rstn = 0, cfg_wr = 0, cfg_rd = 0, req_valid = 0, req_taken;
  logic address_parity_error_n = 1;
  logic [7:0] cfg_addr = 0, req_bus = 0;
  logic [4:0] req_dev = 0;
  logic [3:0] cfg_be = 0;
  logic [15:0] pop;
  logic [31:0] cfg_wdata = 0, cfg_rdata, s = 32'h3633;
  wire cfg_rvalid, req_busy, pci_fwd, wdog_claim;
  wire host_bus_error_n, aliased_mode;
  int fails = 0, compares = 0, cyc = 0;
  logic [31:0] rq[$];
  logic [1:0] eq[$];
  adl_bridge #(.WDOG_CYCLES(8)) u_adl_bridge (.*);
  adl_agent u_adl_agent (.*);
  always #12.5 clk = ~clk;
  function logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one config cycle; a read notes its expected data first
  task acc(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    @(posedge clk);
    cfg_wr    <= w;
    cfg_rd    <= !w;
    cfg_addr  <= a;
    cfg_be    <= 4'hF;
    cfg_wdata <= d;
    if (!w) rq.push_back(e);
    @(posedge clk);
    cfg_wr <= 0; cfg_rd <= 0;
  endtask
  // probe devices 14..31; populated upper ones are claimed by the agent
  task scan(bit p);
    bit wd;
    for (int d = 14; d < 32; d++) begin
      wd = d < 16 || (!p && !pop[d-16]);
      if (d < 16 || !pop[d-16]) eq.push_back(p && d > 15 ? 2'b01 : 2'b10);
      @(posedge clk);
      req_valid <= 1;
      req_bus   <= 8'h00;
      req_dev   <= d[4:0];
      @(posedge clk);
      req_valid <= 0;
      @(posedge clk);
      chk("busy", wd, req_busy);
      repeat (10) @(posedge clk); // watchdog fixed at 8 plus margin
    end
  endtask
  // results are compared against the oldest note as they appear
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      finish_test;
    end else begin
      if (cfg_rvalid !== 1'b0)
        chk("rdata", rq.pop_front(), cfg_rdata);
      if ((pci_fwd | wdog_claim) !== 1'b0)
        chk("event", eq.pop_front(), {wdog_claim, pci_fwd});
    end
  end
  initial begin
    s = lfsr(s); pop = s[15:0];
    repeat (5) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    acc(0, `ADL_OFF_DECODE_MODE, 0, `ADL_RST_DECODE_MODE);
    acc(0, `ADL_OFF_ERR_CMD, 0, `ADL_RST_ERR_CMD);
    acc(0, `ADL_OFF_ABSENT_LOG, 0, `ADL_RST_ABSENT_LOG);
    acc(0, 8'h50, 0, 0);
    scan(0);
    s = lfsr(s);
    acc(1, `ADL_OFF_ABSENT_LOG, {s[31:16], ~pop}, 0);
    acc(0, `ADL_OFF_ABSENT_LOG, 0, {16'h0000, ~pop});
    scan(1);
    for (int k = 0; k < 2; k++) begin
      acc(1, `ADL_OFF_ERR_CMD, k ? 32'h10 : 32'h12, 0);
      address_parity_error_n <= 0;
      repeat (3) @(posedge clk);
      chk("host_bus_error", k, host_bus_error_n);
      address_parity_error_n <= 1;
    end
    acc(1, `ADL_OFF_DECODE_MODE, 32'h0E, 0);
    repeat (2) @(posedge clk);
    chk("alias", 1, aliased_mode);
    repeat (3) @(posedge clk);
    chk("left", 0, rq.size() + eq.size());
    finish_test;
  end
endmodule // adl_bridge_tb
